//--- logic/plc_pkg.sv
// Package with register map, field layouts and timing constants of the indicator/crossover bank.
package plc_pkg;

  // Register offsets on the management port.
  localparam int          ADDR_W          = 5;
  localparam logic [4:0]  OFS_IND_CTRL    = 5'h18;
  localparam logic [4:0]  OFS_XCVR_CTRL   = 5'h19;
  localparam int          DATA_W          = 16;

  // Writable bits of each register; the rest read as zero or as status.
  localparam logic [15:0] IND_WR_MASK     = 16'h07ff;
  localparam logic [15:0] XCVR_WR_MASK    = 16'hc0e0;

  // Reset value of the blink rate field, and a default address that the strapped address field does not use.
  localparam logic [1:0]  BLINK_RST       = 2'h2;
  localparam logic [4:0]  PHY_ADDR_DFLT   = 5'h01;

  // Blink rate encodings.
  localparam logic [1:0]  RATE_50MS       = 2'h0;
  localparam logic [1:0]  RATE_100MS      = 2'h1;
  localparam logic [1:0]  RATE_200MS      = 2'h2;
  localparam logic [1:0]  RATE_500MS      = 2'h3;

  // Blink on/off durations and their cycle counts at the system clock.
  localparam int          CLK_HZ          = 125_000_000;
  localparam int          CYC_PER_MS      = CLK_HZ / 1000;
  localparam int          BLINK_50_MS     = 50;
  localparam int          BLINK_100_MS    = 100;
  localparam int          BLINK_200_MS    = 200;
  localparam int          BLINK_500_MS    = 500;
  localparam int          BLINK_50_CYC    = BLINK_50_MS * CYC_PER_MS;
  localparam int          BLINK_100_CYC   = BLINK_100_MS * CYC_PER_MS;
  localparam int          BLINK_200_CYC   = BLINK_200_MS * CYC_PER_MS;
  localparam int          BLINK_500_CYC   = BLINK_500_MS * CYC_PER_MS;
  localparam int          CNT_W           = 26;

  // Indicator control register layout, most significant bit first.
  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic [1:0] blink_rate;
    logic       rsvd8;
    logic       polarity;
    logic [1:0] rsvd65;
    logic       force_drive;
    logic [1:0] rsvd32;
    logic       force_value;
    logic       rsvd0;
  } plc_ind_ctrl_type;

  // Transceiver control register layout, most significant bit first.
  typedef struct packed {
    logic       auto_mdix_en;
    logic       force_cross;
    logic       pause_rx;
    logic       pause_tx;
    logic       link_100fd;
    logic [2:0] rsvd_mid;
    logic       bypass_stretch;
    logic       rsvd6;
    logic       indicator_mode_select;
    logic [4:0] phy_addr;
  } plc_xcvr_ctrl_type;

  // Pause advertisement pair as seen in the advertisement registers.
  typedef struct packed {
    logic asym_dir;
    logic pause;
  } plc_pause_adv_type;

endpackage

//--- logic/plc_blink_timer.sv
// Blink period timer that emits one tick per selected on/off duration.
`timescale 1ns/10ps
module plc_blink_timer #(
  parameter int unsigned P_50_CYC  = plc_pkg::BLINK_50_CYC,
  parameter int unsigned P_100_CYC = plc_pkg::BLINK_100_CYC,
  parameter int unsigned P_200_CYC = plc_pkg::BLINK_200_CYC,
  parameter int unsigned P_500_CYC = plc_pkg::BLINK_500_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic [1:0] rate,
  input  wire logic       restart,
  output logic            tick
);

  // Map a rate code to its last count value.
  function automatic logic [plc_pkg::CNT_W-1:0] last_count(input logic [1:0] r);
    int unsigned p;
    p = P_200_CYC;
    case (r)
      plc_pkg::RATE_50MS:  p = P_50_CYC;
      plc_pkg::RATE_100MS: p = P_100_CYC;
      plc_pkg::RATE_200MS: p = P_200_CYC;
      default:             p = P_500_CYC;
    endcase
    return plc_pkg::CNT_W'(p - 1);
  endfunction

  logic [plc_pkg::CNT_W-1:0] cnt_ff;
  logic [plc_pkg::CNT_W-1:0] nxt_cnt;
  wire  [plc_pkg::CNT_W-1:0] cnt_last = last_count(rate);
  wire                       at_end   = (cnt_ff >= cnt_last);

  // A shorter rate picked mid-count must not overrun, so the compare is not equality.
  assign tick    = clk_en && !restart && at_end; // R1
  assign nxt_cnt = (restart || at_end) ? '0 : cnt_ff + 1'b1;

  // Counter holds while the clock enable is low.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // The tick only comes at or past the selected count, never early; a frozen count may resume on it.
  a_tick_count: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    tick |-> (cnt_ff >= cnt_last && ($past(cnt_ff) + 1'b1 == cnt_ff || !$past(clk_en))))
    else $error("blink tick at wrong count");

endmodule

//--- logic/plc_indicator_xcvr_ctrl.sv
// Indicator control and transceiver control register bank with link indicator driver.
//
// Summary of operation
// [R1] Blink rate field picks 50, 100, 200 or 500 ms on/off period.
// [R2] Polarity bit: one means active high indicator, zero means active low.
// [R3] Polarity starts from its strap; software writes override it later.
// [R4] Force select drives the software on/off bit onto the indicator.
// [R5] Software on/off bit is read-write and resets to zero.
// [R6] Auto crossover enable gates automatic pair swap; strapped initial value.
// [R7] Force crossover swaps receive and transmit pairs.
// [R8] Pause receive status resolves from local and partner pause bits.
// [R9] Pause transmit status resolves from the same advertisement bits.
// [R10] Pause bits follow standard resolution, only when full duplex resolved.
// [R11] Link status reads one only while 100 Mbps full-duplex link is up.
// [R12] Bypass bit shows raw indicator state without pulse stretching.
// [R13] Mode bit: one shows link only, zero adds activity blinking.
// [R14] Read-only address field returns strapped address captured at reset.
// [R15] Activity blinks at selected period; polarity applied after on/off decision.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
module plc_indicator_xcvr_ctrl #(
  parameter int unsigned P_50_CYC  = plc_pkg::BLINK_50_CYC,
  parameter int unsigned P_100_CYC = plc_pkg::BLINK_100_CYC,
  parameter int unsigned P_200_CYC = plc_pkg::BLINK_200_CYC,
  parameter int unsigned P_500_CYC = plc_pkg::BLINK_500_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic [plc_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [plc_pkg::DATA_W-1:0]  reg_wr_data,
  input  wire logic                        reg_wr_stb,
  input  wire logic                        reg_rd_stb,
  output logic      [plc_pkg::DATA_W-1:0]  reg_rd_data,
  input  wire logic                        strap_polarity,
  input  wire logic                        strap_auto_mdix,
  input  wire logic                        strap_indicator_mode,
  input  wire logic [4:0]                  strap_phy_addr,
  input  wire logic                        link_up,
  input  wire logic                        link_speed_100,
  input  wire logic                        link_full_duplex,
  input  wire logic                        activity,
  input  wire logic                        an_hcd_full_duplex,
  input  wire plc_pkg::plc_pause_adv_type  local_advertisement_reg,
  input  wire plc_pkg::plc_pause_adv_type  partner_ability_reg,
  input  wire logic                        auto_swap_request,
  output logic                             mdix_auto_enable,
  output logic                             pair_swap,
  output logic                             link_indicator_output
);

  plc_pkg::plc_ind_ctrl_type  ind_ff;
  plc_pkg::plc_ind_ctrl_type  nxt_ind;
  plc_pkg::plc_xcvr_ctrl_type xcvr_ff;
  plc_pkg::plc_xcvr_ctrl_type nxt_xcvr;
  plc_pkg::plc_xcvr_ctrl_type xcvr_view;
  logic [plc_pkg::DATA_W-1:0] rd_data_ff;
  logic                       act_seen_ff;
  logic                       stretch_ff;
  logic                       phase_ff;
  logic                       led_out_ff;
  logic                       swap_ff;
  logic                       tick;

  // Address decode of the two registers on the management port.
  wire hit_ind  = (reg_addr == plc_pkg::OFS_IND_CTRL);
  wire hit_xcvr = (reg_addr == plc_pkg::OFS_XCVR_CTRL);
  wire wr_ind   = clk_en && reg_wr_stb && hit_ind;
  wire wr_xcvr  = clk_en && reg_wr_stb && hit_xcvr;

  // Standard pause resolution; the link must have resolved to a full-duplex technology.
  wire lcl_p    = local_advertisement_reg.pause;
  wire lcl_a    = local_advertisement_reg.asym_dir;
  wire prt_p    = partner_ability_reg.pause;
  wire prt_a    = partner_ability_reg.asym_dir;
  wire sym_pz   = lcl_p && prt_p;
  wire pause_rx = an_hcd_full_duplex && (sym_pz || (lcl_p && lcl_a && !prt_p && prt_a)); // R8 R10
  wire pause_tx = an_hcd_full_duplex && (sym_pz || (!lcl_p && lcl_a && prt_p && prt_a)); // R9 R10
  wire link_fd100 = link_up && link_speed_100 && link_full_duplex; // R11

  // Next register values keep only the writable bits of a software write.
  assign nxt_ind  = wr_ind  ? plc_pkg::plc_ind_ctrl_type'(reg_wr_data & plc_pkg::IND_WR_MASK)
                            : ind_ff; // R1 R3 R5
  assign nxt_xcvr = wr_xcvr ? plc_pkg::plc_xcvr_ctrl_type'(
                                (reg_wr_data & plc_pkg::XCVR_WR_MASK) |
                                {11'h000, xcvr_ff.phy_addr})
                            : xcvr_ff; // R6 R14

  // Read view of the transceiver register merges live status into the stored bits.
  always_comb begin
    xcvr_view            = xcvr_ff;
    xcvr_view.pause_rx   = pause_rx; // R8
    xcvr_view.pause_tx   = pause_tx; // R9
    xcvr_view.link_100fd = link_fd100; // R11
    xcvr_view.rsvd_mid   = '0;
  end

  wire [plc_pkg::DATA_W-1:0] rd_sel = hit_ind  ? plc_pkg::DATA_W'(ind_ff) :
                                      hit_xcvr ? plc_pkg::DATA_W'(xcvr_view) :
                                                 '0;

  // Register storage; straps are taken while the synchronous reset is applied.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ind_ff                         <= '0;
      ind_ff.blink_rate              <= plc_pkg::BLINK_RST; // R1
      ind_ff.polarity                <= strap_polarity; // R3
      xcvr_ff                        <= '0;
      xcvr_ff.auto_mdix_en           <= strap_auto_mdix; // R6
      xcvr_ff.indicator_mode_select  <= strap_indicator_mode; // R13
      xcvr_ff.phy_addr               <= strap_phy_addr; // R14
    end else if (clk_en) begin
      ind_ff                         <= nxt_ind;
      xcvr_ff                        <= nxt_xcvr;
    end
  end

  // Read data stand only in the cycle after the strobe; an unmapped address reads zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_data_ff <= '0;
    end else if (clk_en) begin
      rd_data_ff <= reg_rd_stb ? rd_sel : '0;
    end
  end

  assign reg_rd_data      = rd_data_ff;
  assign mdix_auto_enable = xcvr_ff.auto_mdix_en; // R6

  // Blink period source shared by stretching and blinking.
  plc_blink_timer #(
    .P_50_CYC  (P_50_CYC),
    .P_100_CYC (P_100_CYC),
    .P_200_CYC (P_200_CYC),
    .P_500_CYC (P_500_CYC)
  ) u_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .rate    (ind_ff.blink_rate),
    .restart (!stretch_ff),
    .tick    (tick)
  );

  // Activity stretching: a burst keeps the blink going for at least one full period.
  // A new activity in the tick cycle sets the seen flag, so set wins over the clear.
  wire nxt_seen    = activity || (act_seen_ff && !tick);
  wire nxt_stretch = activity ? 1'b1 : (tick ? act_seen_ff : stretch_ff); // R12
  wire nxt_phase   = !stretch_ff ? 1'b1 : (tick ? !phase_ff : phase_ff); // R15

  // Indicator on/off decision before polarity.
  wire on_link     = link_up;
  wire on_raw_act  = link_up && !activity; // R12
  wire on_blink    = link_up && (stretch_ff ? phase_ff : 1'b1); // R15
  wire on_normal   = xcvr_ff.indicator_mode_select ? on_link :
                     (xcvr_ff.bypass_stretch ? on_raw_act : on_blink); // R13 R12
  wire led_level   = ind_ff.polarity ? on_normal : !on_normal; // R2 R15
  wire nxt_led     = ind_ff.force_drive ? ind_ff.force_value : led_level; // R4 R5
  wire nxt_swap    = xcvr_ff.force_cross ||
                     (xcvr_ff.auto_mdix_en && auto_swap_request); // R7 R6

  // Forced value goes to the pin as written; polarity only shapes normal operation.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      act_seen_ff <= 1'b0;
      stretch_ff  <= 1'b0;
      phase_ff    <= 1'b1;
      led_out_ff  <= 1'b0;
      swap_ff     <= 1'b0;
    end else if (clk_en) begin
      act_seen_ff <= nxt_seen;
      stretch_ff  <= nxt_stretch;
      phase_ff    <= nxt_phase;
      led_out_ff  <= nxt_led;
      swap_ff     <= nxt_swap;
    end
  end

  assign link_indicator_output = led_out_ff;
  assign pair_swap             = swap_ff;

  // Checks on the register bank and indicator path.
  a_strap_polarity: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    $past(sys_rst) |-> (ind_ff.polarity == $past(strap_polarity)))
    else $error("polarity not taken from strap");

  a_polarity_override: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    wr_ind |=> (ind_ff.polarity == $past(reg_wr_data[7])))
    else $error("polarity write not applied");

  a_force_drive: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    (clk_en && ind_ff.force_drive) |=> (link_indicator_output == $past(ind_ff.force_value)))
    else $error("forced indicator value not driven");

  a_polarity_level: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    (clk_en && !ind_ff.force_drive && xcvr_ff.indicator_mode_select)
    |=> (link_indicator_output == ($past(ind_ff.polarity) ? $past(link_up) : !$past(link_up))))
    else $error("indicator level or polarity wrong");

  a_onoff_readback: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    (wr_ind ##1 (clk_en && reg_rd_stb && hit_ind))
    |=> (reg_rd_data[1] == $past(reg_wr_data[1], 2)))
    else $error("on/off bit not read back");

  a_pause_full_dup: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    (clk_en && reg_rd_stb && hit_xcvr && !an_hcd_full_duplex) |=> (reg_rd_data[13:12] == 2'h0))
    else $error("pause status without full duplex");

  a_pause_sym: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    (clk_en && reg_rd_stb && hit_xcvr && an_hcd_full_duplex && lcl_p && prt_p)
    |=> (reg_rd_data[13:12] == 2'h3))
    else $error("symmetric pause not resolved");

  a_link_status: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    (clk_en && reg_rd_stb && hit_xcvr) |=> (reg_rd_data[11] == $past(link_fd100)))
    else $error("link status bit wrong");

  a_cross_swap: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    (clk_en && xcvr_ff.force_cross) |=> pair_swap)
    else $error("forced crossover not applied");

  a_addr_ro: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    wr_xcvr |=> $stable(xcvr_ff.phy_addr))
    else $error("address field changed by a write");

  a_mdix_write: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    wr_xcvr |=> (mdix_auto_enable == $past(reg_wr_data[15])))
    else $error("auto crossover enable not written");

  a_bypass_raw: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    (clk_en && !ind_ff.force_drive && !xcvr_ff.indicator_mode_select &&
     xcvr_ff.bypass_stretch && ind_ff.polarity && activity) |=> !link_indicator_output)
    else $error("bypass does not show raw activity");

  a_blink_toggle: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    (clk_en && stretch_ff && tick) |=> (phase_ff != $past(phase_ff)))
    else $error("blink phase did not toggle");

  // Asymmetric and no-pause corners of the pause resolution table.
  a_pause_rx_asym: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    (clk_en && reg_rd_stb && hit_xcvr && an_hcd_full_duplex && lcl_p && lcl_a && !prt_p && prt_a)
    |=> (reg_rd_data[13:12] == 2'h2))
    else $error("asymmetric pause receive not resolved");

  a_pause_tx_asym: assert property (@(posedge mclk) disable iff (sys_rst) // R9
    (clk_en && reg_rd_stb && hit_xcvr && an_hcd_full_duplex && !lcl_p && lcl_a && prt_p && prt_a)
    |=> (reg_rd_data[13:12] == 2'h1))
    else $error("asymmetric pause transmit not resolved");

  a_pause_none: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    (clk_en && reg_rd_stb && hit_xcvr && !lcl_p && !prt_p) |=> (reg_rd_data[13:12] == 2'h0))
    else $error("pause status without any pause advertised");

  // Reset values and straps are visible at the first edge after release; crossover gating and blink-mode indicator checks follow.
  a_blink_reset: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    $past(sys_rst) |-> (ind_ff.blink_rate == plc_pkg::BLINK_RST))
    else $error("blink rate reset value wrong");

  a_onoff_reset: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    $past(sys_rst) |-> !ind_ff.force_value)
    else $error("on/off bit not cleared by reset");

  a_mdix_strap: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    $past(sys_rst) |-> (mdix_auto_enable == $past(strap_auto_mdix)))
    else $error("auto crossover enable not taken from strap");

  a_mode_strap: assert property (@(posedge mclk) disable iff (sys_rst) // R13
    $past(sys_rst) |-> (xcvr_ff.indicator_mode_select == $past(strap_indicator_mode)))
    else $error("indicator mode not taken from strap");

  a_addr_strap: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    $past(sys_rst) |-> (xcvr_ff.phy_addr == $past(strap_phy_addr)))
    else $error("address not taken from strap");

  a_auto_swap_off: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    (clk_en && !xcvr_ff.force_cross && !xcvr_ff.auto_mdix_en) |=> !pair_swap)
    else $error("pairs swapped with auto crossover off");

  a_cross_off: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    (clk_en && !xcvr_ff.force_cross && !auto_swap_request) |=> !pair_swap)
    else $error("pairs swapped without a request");

  a_blink_no_link: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    (clk_en && !ind_ff.force_drive && !xcvr_ff.indicator_mode_select && !link_up)
    |=> (link_indicator_output == !$past(ind_ff.polarity)))
    else $error("indicator lit without link in blink mode");

  a_blink_start_on: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    (clk_en && !stretch_ff) |=> phase_ff)
    else $error("blink phase does not start on");

  c_forced_on: cover property (@(posedge mclk) disable iff (sys_rst)
    ind_ff.force_drive && link_indicator_output);

  c_blink_phase: cover property (@(posedge mclk) disable iff (sys_rst)
    stretch_ff && tick ##1 !phase_ff);

  c_pause_asym: cover property (@(posedge mclk) disable iff (sys_rst)
    pause_tx && !pause_rx);

  c_auto_swap: cover property (@(posedge mclk) disable iff (sys_rst)
    !xcvr_ff.force_cross && pair_swap);

  c_bypass_raw: cover property (@(posedge mclk) disable iff (sys_rst)
    xcvr_ff.bypass_stretch && activity && link_up);

endmodule

//--- verification/plc_led_cable_model.sv
// Model of the status LED and of the twisted-pair wiring beyond the transceiver.
`timescale 1ns/10ps
module plc_led_cable_model (
  input  wire logic pin_level,
  input  wire logic active_high,
  input  wire logic pair_swap,
  output logic      led_lit,
  output logic      rx_on_tx_pair
);
  // The lamp lights at the level chosen by the polarity setting.
  assign led_lit       = (pin_level == active_high);
  // A crossed link receives on the transmit pair.
  assign rx_on_tx_pair = pair_swap;
endmodule

//--- verification/plc_indicator_xcvr_ctrl_tb.sv
// Self-checking testbench for the indicator and transceiver control bank.
`timescale 1ns/10ps
module plc_indicator_xcvr_ctrl_tb;
  localparam int unsigned P_CYC [4] = '{4, 8, 16, 40};
  logic                       mclk = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       clk_en = 1'b1;
  logic [4:0]                 reg_addr = 5'h00;
  logic [15:0]                reg_wr_data = 16'h0000;
  logic                       reg_wr_stb = 1'b0;
  logic                       reg_rd_stb = 1'b0;
  logic [15:0]                reg_rd_data;
  logic                       strap_pol = 1'b1;
  logic                       strap_mdix = 1'b1;
  logic                       strap_mode = 1'b1;
  logic [4:0]                 strap_addr = 5'h01;
  logic                       link_up = 1'b0;
  logic                       spd_100 = 1'b0;
  logic                       full_dup = 1'b0;
  logic                       activity = 1'b0;
  logic                       hcd_fd = 1'b0;
  plc_pkg::plc_pause_adv_type loc_adv = 2'h0;
  plc_pkg::plc_pause_adv_type lp_adv = 2'h0;
  logic                       swap_req = 1'b0;
  logic                       mdix_en;
  logic                       pair_swap;
  logic                       led_pin;
  logic                       led_lit;
  logic                       rx_x;
  logic                       pol_now = 1'b1;
  int                         mismatches = 0;
  int                         total_checks = 0;
  int                         cycles = 0;
  logic [15:0]                d;
  logic                       exp_rx;
  logic                       exp_tx;
  int                         n;

  always #4 mclk = ~mclk;

  plc_indicator_xcvr_ctrl #(.P_50_CYC(4), .P_100_CYC(8), .P_200_CYC(16), .P_500_CYC(40)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
    .reg_rd_data(reg_rd_data), .strap_polarity(strap_pol), .strap_auto_mdix(strap_mdix),
    .strap_indicator_mode(strap_mode), .strap_phy_addr(strap_addr), .link_up(link_up),
    .link_speed_100(spd_100), .link_full_duplex(full_dup), .activity(activity),
    .an_hcd_full_duplex(hcd_fd), .local_advertisement_reg(loc_adv),
    .partner_ability_reg(lp_adv), .auto_swap_request(swap_req), .mdix_auto_enable(mdix_en),
    .pair_swap(pair_swap), .link_indicator_output(led_pin));

  plc_led_cable_model u_far (.pin_level(led_pin), .active_high(pol_now),
    .pair_swap(pair_swap), .led_lit(led_lit), .rx_on_tx_pair(rx_x));

  // A hang ends the run as a failure rather than stalling the simulator.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr_stb  <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= v;
    @(posedge mclk);
    reg_wr_stb  <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are caught there.
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_rd_stb <= 1'b1;
    reg_addr   <= a;
    @(posedge mclk);
    reg_rd_stb <= 1'b0;
    #1 v = reg_rd_data;
  endtask

  // Write then read with no gap between the strobes, as the bus allows.
  task automatic wr_rd(input logic [4:0] a, input logic [15:0] v, output logic [15:0] q);
    @(posedge mclk);
    reg_wr_stb  <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= v;
    @(posedge mclk);
    reg_wr_stb  <= 1'b0;
    reg_rd_stb  <= 1'b1;
    @(posedge mclk);
    reg_rd_stb  <= 1'b0;
    #1 q = reg_rd_data;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    rd(a, d);
    chk_word(d, exp);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    cyc(3);
    sys_rst <= 1'b0;
  endtask

  initial begin
    do_reset();
    rd_chk(5'h18, 16'h0480);
    rd_chk(5'h19, 16'h8021);
    chk_bit(mdix_en, 1'b1);
    $display("test reset values done");
    wr_rd(5'h18, 16'hffff, d);
    chk_word(d, 16'h07ff);
    wr(5'h19, 16'hffff);
    rd_chk(5'h19, 16'hc0e1);
    wr(5'h1a, 16'hffff);
    rd_chk(5'h1a, 16'h0000);
    clk_en <= 1'b0;
    wr(5'h18, 16'h0000);
    clk_en <= 1'b1;
    rd_chk(5'h18, 16'h07ff);
    $display("test access kinds done");
    wr(5'h19, 16'h0020);
    wr(5'h18, 16'h0080);
    link_up <= 1'b1;
    cyc(3);
    chk_bit(led_pin, 1'b1);
    chk_bit(led_lit, 1'b1);
    wr(5'h18, 16'h0000);
    pol_now <= 1'b0;
    cyc(3);
    chk_bit(led_pin, 1'b0);
    link_up <= 1'b0;
    cyc(3);
    chk_bit(led_pin, 1'b1);
    chk_bit(led_lit, 1'b0);
    wr(5'h18, 16'h0012);
    cyc(3);
    chk_bit(led_pin, 1'b1);
    rd_chk(5'h18, 16'h0012);
    wr(5'h18, 16'h0010);
    cyc(3);
    chk_bit(led_pin, 1'b0);
    $display("test indicator drive done");
    wr(5'h19, 16'h4020);
    cyc(3);
    chk_bit(pair_swap, 1'b1);
    chk_bit(rx_x, 1'b1);
    wr(5'h19, 16'h8020);
    swap_req <= 1'b1;
    cyc(3);
    chk_bit(mdix_en, 1'b1);
    chk_bit(pair_swap, 1'b1);
    wr(5'h19, 16'h0020);
    cyc(3);
    chk_bit(pair_swap, 1'b0);
    chk_bit(mdix_en, 1'b0);
    swap_req <= 1'b0;
    $display("test crossover done");
    // Every pause advertisement pair, with and without a full-duplex outcome.
    for (int i = 0; i < 32; i++) begin
      {hcd_fd, loc_adv, lp_adv} <= i[4:0];
      cyc(2);
      exp_rx = hcd_fd & (loc_adv.pause & lp_adv.pause |
        loc_adv.pause & loc_adv.asym_dir & !lp_adv.pause & lp_adv.asym_dir);
      exp_tx = hcd_fd & (loc_adv.pause & lp_adv.pause |
        !loc_adv.pause & loc_adv.asym_dir & lp_adv.pause & lp_adv.asym_dir);
      rd_chk(5'h19, {2'h0, exp_rx, exp_tx, 12'h021});
    end
    {hcd_fd, loc_adv, lp_adv} <= 5'h00;
    for (int i = 0; i < 8; i++) begin
      {link_up, spd_100, full_dup} <= i[2:0];
      cyc(2);
      rd_chk(5'h19, {4'h0, i == 7, 11'h021});
    end
    $display("test status done");
    pol_now <= 1'b1;
    wr(5'h18, 16'h0080);
    wr(5'h19, 16'h0080);
    activity <= 1'b1;
    cyc(3);
    chk_bit(led_pin, 1'b0);
    activity <= 1'b0;
    cyc(3);
    chk_bit(led_pin, 1'b1);
    $display("test bypass done");
    wr(5'h19, 16'h0000);
    activity <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(5'h18, 16'h0080 | (16'(r) << 9));
      cyc(100);
      d[0] = led_pin;
      n = 0;
      while (led_pin === d[0] && n < 200) begin
        cyc(1);
        n++;
      end
      d[0] = led_pin;
      n = 0;
      while (led_pin === d[0] && n < 200) begin
        cyc(1);
        n++;
      end
      chk_word(16'(n), 16'(P_CYC[r]));
    end
    activity <= 1'b0;
    $display("test blink done");
    strap_pol  <= 1'b0;
    strap_mdix <= 1'b0;
    strap_mode <= 1'b0;
    strap_addr <= 5'h0a;
    do_reset();
    rd_chk(5'h18, 16'h0400);
    rd_chk(5'h19, 16'h080a);
    $display("test second reset done");
    give_verdict();
  end
endmodule
